/* File: src/twb_top.sv */
// two-wire bus interface: wishbone register file, master and slave engines
`timescale 1ns/1ps
module twb_top #(
  parameter int ADR_W  = 12,
  parameter int DATA_W = 32
) (
  // clock, reset, enable
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  // wishbone slave
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [ADR_W-1:0]  adr_i,
  input  wire logic [DATA_W/8-1:0] sel_i,
  input  wire logic [DATA_W-1:0] dat_i,
  output logic      [DATA_W-1:0] dat_o,
  output logic                   ack_o,
  // two-wire pins, open drain
  input  wire logic              scl_i,
  output logic                   scl_o,
  output logic                   scl_oe_n_o,
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe_n_o,
  // interrupt
  output logic                   irq_o
);

  if (ADR_W < 10 || DATA_W < 8) begin : g_chk
    $error("twb_top: ADR_W must be >= 10 and DATA_W >= 8");
  end

  // ----------------------------------------
  // register bus
  // ----------------------------------------
  logic [7:0] bus_control, status, transfer_data, own_slave_address;
  logic [7:0] frame_ctrl, irq_status, irq_mask;
  logic       extended_clock_bit;
  logic [7:0] set_ev;

  function automatic logic hit(input logic [ADR_W-3:0] w, input logic [7:0] idx);
    return w == (ADR_W-2)'(idx);
  endfunction

  wire             req   = cyc_i && stb_i;
  wire [ADR_W-3:0] widx  = adr_i[ADR_W-1:2];
  wire             wr    = req && we_i && ack_o && sel_i[0] && ce_i;
  wire [7:0]       wdat  = dat_i[7:0];
  wire             wr_ctl = wr && hit(widx, twb_pkg::IDX_CTRL);
  wire             wr_st  = wr && hit(widx, twb_pkg::IDX_STAT);
  wire             wr_dat = wr && hit(widx, twb_pkg::IDX_DATA);
  wire             wr_adr = wr && hit(widx, twb_pkg::IDX_OWN_ADR);
  wire             wr_md  = wr && hit(widx, twb_pkg::IDX_MODE);
  wire             wr_is  = wr && hit(widx, twb_pkg::IDX_IRQ_ST);
  wire             wr_im  = wr && hit(widx, twb_pkg::IDX_IRQ_MSK);
  wire             wr_tm  = wr && hit(widx, twb_pkg::IDX_TIMER);

  // read selection; unmapped words read as zero
  wire [7:0] rd_byte =
    hit(widx, twb_pkg::IDX_CTRL)    ? bus_control :
    hit(widx, twb_pkg::IDX_STAT)    ? status :
    hit(widx, twb_pkg::IDX_DATA)    ? transfer_data :
    hit(widx, twb_pkg::IDX_OWN_ADR) ? own_slave_address :
    hit(widx, twb_pkg::IDX_MODE)    ? frame_ctrl :
    hit(widx, twb_pkg::IDX_IRQ_ST)  ? irq_status :
    hit(widx, twb_pkg::IDX_IRQ_MSK) ? irq_mask :
    hit(widx, twb_pkg::IDX_TIMER)   ? {7'h00, extended_clock_bit} : 8'h00;

  // one wait state: ack one edge after the request, dropped the next
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= '0;
    end else if (ce_i) begin
      ack_o <= req && !ack_o;
      dat_o <= {{(DATA_W-8){1'b0}}, rd_byte};
    end
  end

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  wire       en       = bus_control[twb_pkg::CTL_EN];
  wire       master_select   = bus_control[twb_pkg::CTL_MASTER];
  wire       transmit_select = bus_control[twb_pkg::CTL_XMIT];
  wire       ack_mode = !bus_control[twb_pkg::CTL_SERIAL];
  wire [2:0] bc       = frame_ctrl[twb_pkg::MODE_BC +: 3];
  wire [3:0] data_bits  = (bc == 3'h0) ? 4'h8 : {1'b0, bc};
  wire [3:0] frame_bits = data_bits + {3'h0, ack_mode};

  // ----------------------------------------
  // master frame sequencer
  // ----------------------------------------
  twb_pkg::twb_state_t state, next_state;
  logic [3:0] bitn;
  logic [7:0] shreg;
  logic       tick;
  wire        go      = wr_dat && en && master_select && (state == twb_pkg::TWB_IDLE);
  wire        m_act   = (state == twb_pkg::TWB_LOW) || (state == twb_pkg::TWB_HIGH);
  wire        m_ackb  = (bitn == data_bits);
  wire        m_last  = (bitn == frame_bits - 1'b1);
  wire        m_txbit = transfer_data[3'(4'h7 - bitn)];

  twb_clk_div #(
    .DIV_W (9)
  ) u_div (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .run_i  (m_act),
    .ext_i  (extended_clock_bit),
    .clk_sel_i (bus_control[twb_pkg::CTL_CLKSEL +: 3]),
    .tick_o (tick)
  );

  // low phase, then released high phase; one bit per pair of ticks
  always_comb begin
    next_state = state;
    case (state)
      twb_pkg::TWB_IDLE: if (go) next_state = twb_pkg::TWB_LOW;
      twb_pkg::TWB_LOW:  if (tick) next_state = twb_pkg::TWB_HIGH;
      twb_pkg::TWB_HIGH: if (tick) next_state = m_last ? twb_pkg::TWB_END
                                                       : twb_pkg::TWB_LOW;
      twb_pkg::TWB_END:  next_state = twb_pkg::TWB_IDLE;
      default:           next_state = twb_pkg::TWB_IDLE;
    endcase
  end

  logic ack_seen;
  always_ff @(posedge clk_i) begin
    if (rst_i || (ce_i && !en)) begin
      state    <= twb_pkg::TWB_IDLE;
      bitn     <= 4'h0;
      shreg    <= 8'h00;
      ack_seen <= 1'b0;
    end else if (ce_i) begin
      state <= next_state;
      if (go) bitn <= 4'h0;
      else if (state == twb_pkg::TWB_HIGH && tick) bitn <= bitn + 1'b1;
      if (state == twb_pkg::TWB_HIGH && tick && !m_ackb) shreg <= {shreg[6:0], sda_i};
      if (state == twb_pkg::TWB_HIGH && tick && m_ackb) ack_seen <= !sda_i;
    end
  end

  // ----------------------------------------
  // slave engine, pins sampled directly
  // ----------------------------------------
  logic       scl_q, sda_q, sl_first, sl_sel, bus_busy;
  logic [3:0] sl_cnt;
  logic [7:0] sl_sh;
  wire  s_on     = en && !master_select;
  wire  start_c  = scl_i && scl_q && sda_q && !sda_i;
  wire  stop_c   = scl_i && scl_q && !sda_q && sda_i;
  wire  scl_rise = scl_i && !scl_q;
  wire  scl_fall = !scl_i && scl_q;
  wire  s_ackb   = (sl_cnt == data_bits);
  wire  s_end    = s_on && scl_fall && (sl_cnt == frame_bits - 1'b1);
  // format_select high disables address recognition
  wire  addr_hit = sl_first && !own_slave_address[twb_pkg::ADR_FMT] &&
                   (sl_sh[7:1] == own_slave_address[7:1]);
  wire  s_txbit  = transfer_data[3'(4'h7 - sl_cnt)];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      sl_first <= 1'b0;
      sl_sel   <= 1'b0;
      bus_busy <= 1'b0;
      sl_cnt   <= 4'h0;
      sl_sh    <= 8'h00;
    end else if (ce_i) begin
      scl_q <= scl_i;
      sda_q <= sda_i;
      if (start_c) bus_busy <= 1'b1;
      else if (stop_c) bus_busy <= 1'b0;
      if (!s_on || stop_c) begin
        sl_first <= 1'b0;
        sl_sel   <= 1'b0;
        sl_cnt   <= 4'h0;
      end else if (start_c) begin
        sl_first <= 1'b1;
        sl_sel   <= 1'b0;
        sl_cnt   <= 4'h0;
      end else if (s_end) begin
        sl_cnt <= 4'h0;
        if (sl_first) sl_sel <= addr_hit;
        sl_first <= 1'b0;
      end else if (scl_fall) begin
        sl_cnt <= sl_cnt + 1'b1;
      end
      if (s_on && scl_rise && sl_cnt < data_bits) sl_sh <= {sl_sh[6:0], sda_i};
    end
  end

  // ----------------------------------------
  // pin drive, open drain: oe_n low pulls the wire low
  // ----------------------------------------
  wire m_sda_low = m_act && (transmit_select ? (!m_ackb && !m_txbit)
                                             : (m_ackb && ack_mode));
  wire s_sda_low = s_on && !scl_i &&
                   ((s_ackb && ack_mode && (addr_hit || (sl_sel && !transmit_select))) ||
                    (sl_sel && transmit_select && !sl_first && sl_cnt < data_bits && !s_txbit));
  assign scl_o      = 1'b0;
  assign sda_o      = 1'b0;
  assign scl_oe_n_o = !(en && state == twb_pkg::TWB_LOW);
  assign sda_oe_n_o = !(en && (m_sda_low || s_sda_low));

  // ----------------------------------------
  // events, status, interrupt
  // ----------------------------------------
  wire m_done = (state == twb_pkg::TWB_END);
  assign set_ev = {1'b0,
                   m_done || (s_end && (sl_sel || addr_hit)),
                   2'b00,
                   s_on && start_c,
                   s_end && addr_hit,
                   m_done && ack_mode && !ack_seen && transmit_select,
                   1'b0};

  // hardware set wins over a clearing write in the same cycle
  wire [7:0] st_clr = wr_st ? (~wdat & twb_pkg::ST_FLAGS) : 8'h00;
  wire [7:0] is_clr = wr_is ? wdat : 8'h00;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_control        <= twb_pkg::CTRL_RST;
      own_slave_address  <= twb_pkg::ADR_RST;
      frame_ctrl         <= twb_pkg::MODE_RST;
      irq_mask           <= twb_pkg::MSK_RST;
      extended_clock_bit <= 1'b0;
    end else if (ce_i) begin
      if (wr_ctl) bus_control <= wdat;
      if (wr_adr) own_slave_address <= wdat;
      if (wr_md)  frame_ctrl <= {5'h00, wdat[2:0]};
      if (wr_im)  irq_mask <= wdat & twb_pkg::ST_FLAGS;
      if (wr_tm)  extended_clock_bit <= wdat[twb_pkg::TMR_EXT];
    end
  end

  // received byte lands in the data register; a CPU write takes priority
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      transfer_data <= twb_pkg::DATA_RST;
    end else if (ce_i) begin
      if (wr_dat) transfer_data <= wdat;
      else if (m_done && !transmit_select) transfer_data <= shreg;
      else if (s_end && sl_sel && !transmit_select) transfer_data <= sl_sh;
    end
  end

  wire [7:0] st_live = {bus_busy, 6'h00, state != twb_pkg::TWB_IDLE};
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status     <= twb_pkg::STAT_RST;
      irq_status <= twb_pkg::STAT_RST;
      irq_o      <= 1'b0;
    end else if (ce_i) begin
      status <= (((status & ~st_clr) | set_ev) & twb_pkg::ST_FLAGS) | st_live;
      irq_status <= (irq_status & ~is_clr) | set_ev;
      irq_o <= bus_control[twb_pkg::CTL_IRQ_EN] && |(irq_status & irq_mask);
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic [3:0] hcnt;
  always_ff @(posedge clk_i) begin
    if (rst_i || state == twb_pkg::TWB_IDLE) hcnt <= 4'h0;
    else if (state == twb_pkg::TWB_HIGH && tick) hcnt <= hcnt + 1'b1;
  end

  property p_off_hiz;
    !en |-> scl_oe_n_o && sda_oe_n_o;
  endproperty
  a_off_hiz: assert property (p_off_hiz) else $error("pins driven while off");

  property p_on_drive;
    en && state == twb_pkg::TWB_LOW |-> !scl_oe_n_o;
  endproperty
  a_on_drive: assert property (p_on_drive) else $error("clock not driven");

  property p_irq_mask;
    !bus_control[twb_pkg::CTL_IRQ_EN] ##1 !bus_control[twb_pkg::CTL_IRQ_EN] |-> !irq_o;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked irq seen");

  property p_role;
    state == twb_pkg::TWB_LOW && $past(state) == twb_pkg::TWB_IDLE |-> $past(master_select);
  endproperty
  a_role: assert property (p_role) else $error("master frame in slave role");

  property p_rx_release;
    en && master_select && m_act && !transmit_select && !m_ackb |-> sda_oe_n_o;
  endproperty
  a_rx_release: assert property (p_rx_release) else $error("rx data driven");

  property p_w0c;
    wr_st && !wdat[twb_pkg::ST_DONE] && !set_ev[twb_pkg::ST_DONE] |=>
      !status[twb_pkg::ST_DONE];
  endproperty
  a_w0c: assert property (p_w0c) else $error("flag not cleared");

  property p_no_w1set;
    wr_st && set_ev == 8'h00 && ce_i |=>
      ((status & ~$past(status)) & twb_pkg::ST_FLAGS) == 8'h00;
  endproperty
  a_no_w1set: assert property (p_no_w1set) else $error("write set a flag");

  property p_frame_len;
    state == twb_pkg::TWB_END |-> hcnt == frame_bits;
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame length wrong");

  c_master_tx: cover property (m_done && transmit_select);
  c_master_rx: cover property (m_done && !transmit_select);
  c_slave_hit: cover property (s_end && addr_hit);
  c_irq_rise:  cover property (!irq_o ##1 irq_o);

endmodule

/* File: src/twb_pkg.sv */
// constants, register map and state type of the two-wire bus interface
package twb_pkg;

  // ----------------------------------------
  // register indices (byte address = index * 4)
  // ----------------------------------------
  localparam logic [7:0] IDX_CTRL    = 8'ha0;
  localparam logic [7:0] IDX_STAT    = 8'ha1;
  localparam logic [7:0] IDX_DATA    = 8'ha2;
  localparam logic [7:0] IDX_OWN_ADR = 8'ha3;
  localparam logic [7:0] IDX_MODE    = 8'ha4;
  localparam logic [7:0] IDX_IRQ_ST  = 8'ha5;
  localparam logic [7:0] IDX_IRQ_MSK = 8'ha6;
  localparam logic [7:0] IDX_TIMER   = 8'ha7;

  // ----------------------------------------
  // bus_control fields
  // ----------------------------------------
  localparam int CTL_EN     = 7;
  localparam int CTL_IRQ_EN = 6;
  localparam int CTL_MASTER = 5;
  localparam int CTL_XMIT   = 4;
  localparam int CTL_SERIAL = 3;
  localparam int CTL_CLKSEL = 0;

  // ----------------------------------------
  // status fields, frame_count field, address field
  // ----------------------------------------
  localparam int ST_BUS_BUSY = 7;
  localparam int ST_DONE     = 6;
  localparam int ST_START    = 3;
  localparam int ST_ADDR     = 2;
  localparam int ST_NACK     = 1;
  localparam int ST_XFER     = 0;
  localparam logic [7:0] ST_FLAGS = 8'h4e;
  localparam int MODE_BC = 0;
  localparam int ADR_FMT = 0;
  localparam int TMR_EXT = 0;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] ADR_RST  = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [7:0] MSK_RST  = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;

  // ----------------------------------------
  // serial clock divisors, normal and extended
  // ----------------------------------------
  localparam logic [8:0] DIV_STD [8] = '{9'h01c, 9'h028, 9'h030, 9'h040,
                                         9'h050, 9'h064, 9'h070, 9'h080};
  localparam logic [8:0] DIV_EXT [8] = '{9'h038, 9'h050, 9'h060, 9'h080,
                                         9'h0a0, 9'h0c8, 9'h0e0, 9'h100};

  // master frame sequencer, gray coded along idle-low-high-end
  typedef enum logic [1:0] {
    TWB_IDLE = 2'b00,
    TWB_LOW  = 2'b01,
    TWB_HIGH = 2'b11,
    TWB_END  = 2'b10
  } twb_state_t;

endpackage

/* File: src/twb_clk_div.sv */
// serial clock divider: one tick per half period of the selected rate
`timescale 1ns/1ps
module twb_clk_div #(
  parameter int DIV_W = 9
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  // selection
  input  wire logic       run_i,
  input  wire logic       ext_i,
  input  wire logic [2:0] clk_sel_i,
  // half period strobe
  output logic            tick_o
);

  // ----------------------------------------
  // divisor lookup
  // ----------------------------------------
  if (DIV_W < 9) begin : g_chk
    $error("twb_clk_div: DIV_W must hold a divisor of 256");
  end

  logic [DIV_W-1:0] cnt;
  logic [DIV_W-1:0] gap;
  logic             gap_ok;
  logic [3:0]       cfg_q;
  wire  [8:0]       div_sel = ext_i ? twb_pkg::DIV_EXT[clk_sel_i]
                                    : twb_pkg::DIV_STD[clk_sel_i];
  wire  [DIV_W-1:0] half    = DIV_W'(div_sel[8:1]);
  wire              hit     = run_i && (cnt == half - 1'b1);
  wire              cfg_chg = (cfg_q != {ext_i, clk_sel_i});

  assign tick_o = hit && ce_i;

  // counter restarts whenever the engine idles so phases start clean
  always_ff @(posedge clk_i) begin
    if (rst_i || (ce_i && (!run_i || hit))) begin
      cnt <= '0;
    end else if (ce_i) begin
      cnt <= cnt + 1'b1;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i || cfg_chg) begin
      gap    <= '0;
      gap_ok <= 1'b0;
    end else if (tick_o) begin
      gap    <= '0;
      gap_ok <= 1'b1;
    end else if (ce_i) begin
      gap <= gap + 1'b1;
    end
    cfg_q <= {ext_i, clk_sel_i};
  end

  property p_std_rate;
    @(posedge clk_i) disable iff (rst_i)
    tick_o && gap_ok && !ext_i && !cfg_chg |->
      ({gap, 1'b0} + 2'd2) == (DIV_W+1)'(twb_pkg::DIV_STD[clk_sel_i]);
  endproperty
  a_std_rate: assert property (p_std_rate) else $error("std divisor wrong");

  property p_ext_rate;
    @(posedge clk_i) disable iff (rst_i)
    tick_o && gap_ok && ext_i && !cfg_chg |->
      ({gap, 1'b0} + 2'd2) == (DIV_W+1)'(twb_pkg::DIV_EXT[clk_sel_i]);
  endproperty
  a_ext_rate: assert property (p_ext_rate) else $error("ext divisor wrong");

endmodule

/* File: verification/twb_bus_node.sv */
// partner node on the two-wire bus: receives or sends one byte per master frame
`timescale 1ns/1ps
module twb_bus_node (
  // clock and frame restart
  input  wire logic       clk_i,
  input  wire logic       clr_i,
  // resolved wire levels
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  // behaviour chosen by the bench
  input  wire logic       rx_mode_i,
  input  wire logic       ack_en_i,
  input  wire logic [7:0] tx_byte_i,
  // data pin pull and captured byte
  output logic            sda_oe_n_o,
  output logic [7:0]      rx_byte_o
);
  logic       scl_q;
  logic [3:0] idx;

  // data changes only after a clock fall, so no start or stop is faked mid frame
  always @(posedge clk_i) begin
    scl_q <= scl_i;
    if (clr_i) begin
      idx        <= 4'h0;
      sda_oe_n_o <= 1'b1;
    end else if (scl_q && !scl_i) begin
      idx        <= idx + 4'h1;
      sda_oe_n_o <= !((rx_mode_i && idx < 4'h8 && !tx_byte_i[3'h7 - idx[2:0]]) ||
                      (!rx_mode_i && ack_en_i && idx == 4'h8));
    end else if (!scl_q && scl_i && idx <= 4'h8) begin
      rx_byte_o <= {rx_byte_o[6:0], sda_i}; // msb first
    end
  end
endmodule

/* File: verification/two_wire_bus_interface_regs_test.sv */
// self-checking bench of the two-wire bus interface register block
`timescale 1ns/1ps
module two_wire_bus_interface_regs_test;
  typedef struct {logic [7:0] idx; logic [7:0] wd; logic [7:0] exp;} twb_row_t;
  localparam logic [7:0] MTX = 8'hf0;
  localparam logic [7:0] MRX = 8'he0;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic [11:0] adr   = 12'h000;
  logic [3:0]  sel   = 4'h0;
  logic [31:0] wdat  = 32'h0000_0000;
  logic [31:0] rdat;
  logic        ack, scl_o, scl_oe_n, sda_o, sda_oe_n, irq, node_oe_n;
  logic        nclr  = 1'b1;
  logic        nrx   = 1'b0;
  logic        nack  = 1'b1;
  logic        oe_q  = 1'b1;
  logic [7:0]  ntx   = 8'h00;
  logic [7:0]  nrxb, rd;
  int          n_mismatch = 0;
  int          cmp_count  = 0;
  int          low_cyc    = 0;
  int          n_pulse    = 0;
  int          p;
  int          div_n [8]  = '{28, 40, 48, 64, 80, 100, 112, 128};
  int          div_x [8]  = '{56, 80, 96, 128, 160, 200, 224, 256};
  // both wires have pull-ups: released means high
  wire         scl_w = scl_oe_n ? 1'b1 : scl_o;
  wire         sda_w = (sda_oe_n ? 1'b1 : sda_o) & node_oe_n;
  twb_row_t    rows [7] = '{
    '{twb_pkg::IDX_OWN_ADR, 8'h5a, 8'h5a}, '{twb_pkg::IDX_MODE, 8'h05, 8'h05},
    '{twb_pkg::IDX_IRQ_MSK, 8'h40, 8'h40}, '{twb_pkg::IDX_TIMER, 8'h01, 8'h01},
    '{twb_pkg::IDX_CTRL, 8'h47, 8'h47}, '{twb_pkg::IDX_DATA, 8'h3c, 8'h3c},
    '{8'h10, 8'hff, 8'h00}};

  twb_top dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .scl_i(scl_w), .scl_o(scl_o), .scl_oe_n_o(scl_oe_n),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n), .irq_o(irq));
  twb_bus_node node (
    .clk_i(clk_i), .clr_i(nclr), .scl_i(scl_w), .sda_i(sda_w), .rx_mode_i(nrx),
    .ack_en_i(nack), .tx_byte_i(ntx), .sda_oe_n_o(node_oe_n), .rx_byte_o(nrxb));

  // ----------------------------------------
  // clock, pin monitor, checks, bus cycles
  // ----------------------------------------
  initial begin
    forever #25 clk_i = ~clk_i;
  end

  // sampled on the falling edge so counts never race the launching edge
  always @(negedge clk_i) begin
    oe_q <= scl_oe_n;
    if (scl_oe_n === 1'b0) low_cyc++;
    if (oe_q === 1'b1 && scl_oe_n === 1'b0) n_pulse++;
  end

  task automatic chk_reg(input string name, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_num(input string name, input int exp, input int got);
    cmp_count++;
    if (got != exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %0d seen %0d", name, exp, got);
    end
  endtask

  // classic single cycle; request held until ack is seen at a rising edge
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= {2'b00, idx, 2'b00};
    sel  <= 4'hf;
    wdat <= {24'h00_0000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = rdat[7:0];
    if (n >= 20) n_mismatch++;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic rdc(input string name, input logic [7:0] idx, input logic [7:0] exp);
    wb(1'b0, idx, 8'h00);
    chk_reg(name, exp, rd);
  endtask

  // one master frame, measured on the clock pin, ended by the done interrupt
  task automatic frame(input logic [7:0] ctl, input logic [7:0] bc, input logic ext,
                       input logic [7:0] d, input int bits, input int div_v);
    int n;
    int l0;
    n = 0;
    nclr <= 1'b1;
    wb(1'b1, twb_pkg::IDX_TIMER, {7'h00, ext});
    wb(1'b1, twb_pkg::IDX_MODE, bc);
    wb(1'b1, twb_pkg::IDX_IRQ_MSK, 8'h40);
    wb(1'b1, twb_pkg::IDX_CTRL, ctl);
    nclr <= 1'b0;
    p  = n_pulse;
    l0 = low_cyc;
    wb(1'b1, twb_pkg::IDX_DATA, d);
    while (irq !== 1'b1 && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 3000) n_mismatch++;
    chk_num("scl pulses", bits, n_pulse - p);
    chk_num("scl low cycles", bits * div_v / 2, low_cyc - l0);
    wb(1'b1, twb_pkg::IDX_IRQ_ST, 8'hff);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clk_i);
    chk_reg("pins in reset", 8'h03, {6'h00, scl_oe_n, sda_oe_n});
    rst_i <= 1'b0;
    rdc("control reset", twb_pkg::IDX_CTRL, 8'h00);
    rdc("address reset", twb_pkg::IDX_OWN_ADR, 8'h00);
    rdc("status reset", twb_pkg::IDX_STAT, 8'h00);
    chk_reg("irq reset", 8'h00, {7'h00, irq});
    $display("reset test done");
    // own address row is a unique bus address
    foreach (rows[i]) begin
      wb(1'b1, rows[i].idx, rows[i].wd);
      rdc("register readback", rows[i].idx, rows[i].exp);
    end
    wb(1'b1, twb_pkg::IDX_CTRL, 8'h00);
    $display("register rows done");
    for (int e = 0; e < 2; e++) begin
      for (int c = 0; c < 8; c++) begin
        frame(MTX | 8'(c), 8'h01, e[0], 8'h80, 2, e ? div_x[c] : div_n[c]);
      end
    end
    $display("divider sweep done");
    // short sweep frames end unacked, so drop their sticky no-ack flag first
    wb(1'b1, twb_pkg::IDX_STAT, 8'h00);
    frame(MTX, 8'h00, 1'b0, 8'ha5, 9, 28);
    chk_reg("sent byte", 8'ha5, nrxb);
    rdc("status after ack", twb_pkg::IDX_STAT, 8'h40);
    frame(MTX | 8'h08, 8'h00, 1'b0, 8'h96, 8, 28);
    chk_reg("serial byte", 8'h96, nrxb);
    frame(MTX, 8'h03, 1'b0, 8'hff, 4, 28);
    nrx <= 1'b1;
    ntx <= 8'h3c;
    frame(MRX, 8'h00, 1'b0, 8'h00, 9, 28);
    rdc("received byte", twb_pkg::IDX_DATA, 8'h3c);
    nrx  <= 1'b0;
    nack <= 1'b0;
    wb(1'b1, twb_pkg::IDX_STAT, 8'h00);
    frame(MTX, 8'h00, 1'b0, 8'hc3, 9, 28);
    chk_reg("unacked byte", 8'hc3, nrxb);
    wb(1'b1, twb_pkg::IDX_STAT, 8'hff);
    wb(1'b0, twb_pkg::IDX_STAT, 8'h00);
    chk_reg("flags kept", 8'h42, rd & twb_pkg::ST_FLAGS);
    wb(1'b1, twb_pkg::IDX_STAT, 8'h0c);
    wb(1'b0, twb_pkg::IDX_STAT, 8'h00);
    chk_reg("flags cleared", 8'h00, rd & twb_pkg::ST_FLAGS);
    $display("frame tests done");
    for (int r = 0; r < 2; r++) begin
      p = n_pulse;
      wb(1'b1, twb_pkg::IDX_CTRL, r ? 8'h90 : 8'h80);
      wb(1'b1, twb_pkg::IDX_DATA, 8'h55);
      repeat (300) @(posedge clk_i);
      chk_num("slave role pulses", 0, n_pulse - p);
    end
    wb(1'b1, twb_pkg::IDX_CTRL, 8'hb0);
    wb(1'b1, twb_pkg::IDX_DATA, 8'h0f);
    repeat (300) @(posedge clk_i);
    chk_reg("irq masked", 8'h00, {7'h00, irq});
    wb(1'b1, twb_pkg::IDX_CTRL, 8'hf0);
    repeat (3) @(posedge clk_i);
    chk_reg("irq enabled", 8'h01, {7'h00, irq});
    wb(1'b1, twb_pkg::IDX_IRQ_ST, 8'hff);
    repeat (3) @(posedge clk_i);
    chk_reg("irq cleared", 8'h00, {7'h00, irq});
    $display("role and interrupt tests done");
    // disabling in mid frame must let go of both wires at once
    p = n_pulse;
    wb(1'b1, twb_pkg::IDX_DATA, 8'h00);
    repeat (40) @(posedge clk_i);
    chk_num("engine drives", 1, int'(n_pulse > p));
    wb(1'b1, twb_pkg::IDX_CTRL, 8'h00);
    @(posedge clk_i);
    chk_reg("pins released", 8'h03, {6'h00, scl_oe_n, sda_oe_n});
    $display("disable test done");
    wrap_up();
  end

  // watchdog sized well above the expected run of about 6200 cycles
  initial begin
    repeat (60000) @(posedge clk_i);
    n_mismatch++;
    wrap_up();
  end
endmodule
